// [core/gyc_config.v]
// rate output control, restart command and interrupt pin configuration behind an axi4-lite slave
//
// Overview of operation
// - rate bit 7 selects unfiltered samples
// - lock_disable bit 6 turns byte locking off
// - low-byte read freezes that axis' high byte
// - high-byte read releases the freeze
// - only B6 written to restart resets
// - after delay, configuration returns to defaults
// - restart accepted in every mode
// - new-sample interrupt needs enable bit 7
// - queue interrupt needs enable bit 6
// - bias correction runs only with bit 2
// - pin B drive type from bit 3
// - pin A drive type from bit 1
// - pin B polarity from bit 2
// - pin A polarity from bit 0
// - fast-rate event to pin A via bit 3
// - motion event to pin A via bit 1
// - four events routed per pin by 0x18
`timescale 1ns/1ps
`default_nettype none
`include "gyc_defines.vh"

module gyc_config #(
  parameter integer RESTART_CYCLES = `GYC_RESTART_CYCLES
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // axi4-lite write address and data
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // rate samples, x in the low word, from same-clock logic
  input  wire [47:0] filteredRate,
  input  wire [47:0] unfilteredRate,
  input  wire        sampleValid,
  // event levels from the detectors
  input  wire        newSampleEvt,
  input  wire        queueEvt,
  input  wire        fastBiasEvt,
  input  wire        autoBiasEvt,
  input  wire        fastRateEvt,
  input  wire        motionEvt,
  // controls toward the core
  output reg         biasCorrectEn,
  output reg         coreReset,
  // interrupt pins
  output reg         irqPinAOut,
  output reg         irqPinAOe,
  output reg         irqPinBOut,
  output reg         irqPinBOe
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and restart timer

  reg  [7:0]  rateCtrl;
  reg  [7:0]  srcEnable;
  reg  [7:0]  pinCfg;
  reg  [7:0]  pinARoute;
  reg  [7:0]  pinRoute;
  reg         restartPending;
  reg  [15:0] restartCount;

  reg  [9:0]  awAddr;
  reg         awHeld;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         wHeld;

  wire [7:0]  wIdx    = awAddr[9:2];
  wire        doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire        wrLane0 = doWrite && wStrb[0];
  wire [7:0]  wByte   = wData[7:0];
  wire        wrMapped = (wIdx == `GYC_IDX_RATE_CTRL) || (wIdx == `GYC_IDX_RESTART) ||
                         (wIdx == `GYC_IDX_SRC_EN) || (wIdx == `GYC_IDX_PIN_CFG) ||
                         (wIdx == `GYC_IDX_PIN_A_ROUTE) || (wIdx == `GYC_IDX_PIN_ROUTE);
  // restart decode does not look at any mode bit, so it works in all power modes
  wire        restartHit = wrLane0 && (wIdx == `GYC_IDX_RESTART) &&
                           (wByte == `GYC_RESTART_CODE);
  wire        restartDone = restartPending && (restartCount == 16'h0001);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rateCtrl       <= `GYC_RST_RATE_CTRL;
      srcEnable      <= `GYC_RST_SRC_EN;
      pinCfg         <= `GYC_RST_PIN_CFG;
      pinARoute      <= `GYC_RST_PIN_A_ROUTE;
      pinRoute       <= `GYC_RST_PIN_ROUTE;
      restartPending <= 1'b0;
      restartCount   <= 16'h0000;
      coreReset      <= 1'b0;
    end else begin
      coreReset <= restartDone;
      if (restartDone) begin
        // defaults win over a write landing in the same cycle
        rateCtrl       <= `GYC_RST_RATE_CTRL;
        srcEnable      <= `GYC_RST_SRC_EN;
        pinCfg         <= `GYC_RST_PIN_CFG;
        pinARoute      <= `GYC_RST_PIN_A_ROUTE;
        pinRoute       <= `GYC_RST_PIN_ROUTE;
        restartPending <= 1'b0;
        restartCount   <= 16'h0000;
      end else begin
        if (restartHit && !restartPending) begin
          restartPending <= 1'b1;
          restartCount   <= RESTART_CYCLES[15:0];
        end else if (restartPending) begin
          restartCount <= restartCount - 16'h0001;
        end
        if (wrLane0) begin
          if (wIdx == `GYC_IDX_RATE_CTRL) begin
            rateCtrl <= wByte & `GYC_MASK_RATE_CTRL;
          end else if (wIdx == `GYC_IDX_SRC_EN) begin
            srcEnable <= wByte & `GYC_MASK_SRC_EN;
          end else if (wIdx == `GYC_IDX_PIN_CFG) begin
            pinCfg <= wByte & `GYC_MASK_PIN_CFG;
          end else if (wIdx == `GYC_IDX_PIN_A_ROUTE) begin
            pinARoute <= wByte & `GYC_MASK_PIN_A_ROUTE;
          end else if (wIdx == `GYC_IDX_PIN_ROUTE) begin
            pinRoute <= wByte;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr       <= 10'h000;
      awHeld       <= 1'b0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      wHeld        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GYC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `GYC_RESP_OKAY : `GYC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate samples with high-byte lock per axis

  reg  [15:0] liveRate [0:2];
  reg  [7:0]  heldHigh [0:2];
  reg  [2:0]  axisLocked;

  wire [7:0]  rIdx     = s_axi_araddr[9:2];
  wire        doRead   = s_axi_arvalid && s_axi_arready;
  wire [7:0]  rateOfs  = rIdx - `GYC_IDX_RATE_BASE;
  wire        rateHit  = (rIdx >= `GYC_IDX_RATE_BASE) && (rateOfs < 8'h06);
  wire [1:0]  rateAxis = rateOfs[2:1];
  wire        lockOn   = !rateCtrl[`GYC_BIT_LOCK_DIS];

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : gAxis
      wire lowRead  = doRead && rateHit && (rateAxis == ax) && !rateOfs[0];
      wire highRead = doRead && rateHit && (rateAxis == ax) && rateOfs[0];
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          liveRate[ax]   <= 16'h0000;
          heldHigh[ax]   <= 8'h00;
          axisLocked[ax] <= 1'b0;
        end else begin
          if (sampleValid) begin
            liveRate[ax] <= rateCtrl[`GYC_BIT_UNFILT] ? unfilteredRate[16*ax +: 16]
                                                      : filteredRate[16*ax +: 16];
          end
          // the high byte copied on a low read is the one paired with the returned low byte
          if (lowRead && lockOn) begin
            axisLocked[ax] <= 1'b1;
            heldHigh[ax]   <= liveRate[ax][15:8];
          end else if (highRead || !lockOn) begin
            axisLocked[ax] <= 1'b0;
          end
          if (!axisLocked[ax] && !(lowRead && lockOn)) begin
            heldHigh[ax] <= liveRate[ax][15:8];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign s_axi_arready = !s_axi_rvalid;

  reg  [7:0]  rByte;
  reg         rMapped;

  always @* begin
    rByte   = 8'h00;
    rMapped = 1'b1;
    if (rIdx == `GYC_IDX_RATE_CTRL) begin
      rByte = rateCtrl;
    end else if (rIdx == `GYC_IDX_RESTART) begin
      rByte = 8'h00;
    end else if (rIdx == `GYC_IDX_SRC_EN) begin
      rByte = srcEnable;
    end else if (rIdx == `GYC_IDX_PIN_CFG) begin
      rByte = pinCfg;
    end else if (rIdx == `GYC_IDX_PIN_A_ROUTE) begin
      rByte = pinARoute;
    end else if (rIdx == `GYC_IDX_PIN_ROUTE) begin
      rByte = pinRoute;
    end else if (rIdx == `GYC_IDX_STATUS) begin
      rByte = {4'h0, axisLocked, restartPending};
    end else if (rateHit) begin
      // a locked axis serves its frozen high byte, otherwise the live high byte as copied at the previous edge
      rByte = rateOfs[0] ? heldHigh[rateAxis] : liveRate[rateAxis][7:0];
    end else begin
      rMapped = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `GYC_RESP_OKAY;
    end else begin
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rByte};
        s_axi_rresp  <= rMapped ? `GYC_RESP_OKAY : `GYC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event gating, routing and pin drive

  wire newGated   = newSampleEvt && srcEnable[`GYC_BIT_NEW_EN];
  wire queueGated = queueEvt && srcEnable[`GYC_BIT_QUEUE_EN];
  wire biasGated  = autoBiasEvt && srcEnable[`GYC_BIT_BIAS_EN];

  wire pinAActive = (fastRateEvt && pinARoute[`GYC_BIT_A_FAST])
                 || (motionEvt && pinARoute[`GYC_BIT_A_MOTION])
                 || (newGated && pinRoute[`GYC_BIT_A_NEW])
                 || (fastBiasEvt && pinRoute[`GYC_BIT_A_FBIAS])
                 || (queueGated && pinRoute[`GYC_BIT_A_QUEUE])
                 || (biasGated && pinRoute[`GYC_BIT_A_ABIAS]);
  wire pinBActive = (newGated && pinRoute[`GYC_BIT_B_NEW])
                 || (fastBiasEvt && pinRoute[`GYC_BIT_B_FBIAS])
                 || (queueGated && pinRoute[`GYC_BIT_B_QUEUE])
                 || (biasGated && pinRoute[`GYC_BIT_B_ABIAS]);

  // polarity bit 1 means active high, so level equals activity xor not-polarity
  wire pinALevel = pinAActive ^ !pinCfg[`GYC_BIT_A_POL];
  wire pinBLevel = pinBActive ^ !pinCfg[`GYC_BIT_B_POL];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPinAOut    <= 1'b0;
      irqPinAOe     <= 1'b0;
      irqPinBOut    <= 1'b0;
      irqPinBOe     <= 1'b0;
      biasCorrectEn <= 1'b0;
    end else begin
      biasCorrectEn <= srcEnable[`GYC_BIT_BIAS_EN];
      // open drain only ever pulls low; a high level is left to the pull-up
      if (pinCfg[`GYC_BIT_A_DRIVE]) begin
        irqPinAOut <= 1'b0;
        irqPinAOe  <= !pinALevel;
      end else begin
        irqPinAOut <= pinALevel;
        irqPinAOe  <= 1'b1;
      end
      if (pinCfg[`GYC_BIT_B_DRIVE]) begin
        irqPinBOut <= 1'b0;
        irqPinBOe  <= !pinBLevel;
      end else begin
        irqPinBOut <= pinBLevel;
        irqPinBOe  <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [core/gyc_defines.vh]
// register indices, field positions, reset values and timing for the rate configuration bank
`ifndef GYC_DEFINES_VH
`define GYC_DEFINES_VH

// register indices; the byte address is four times the index
`define GYC_IDX_RATE_CTRL   8'h13
`define GYC_IDX_RESTART     8'h14
`define GYC_IDX_SRC_EN      8'h15
`define GYC_IDX_PIN_CFG     8'h16
`define GYC_IDX_PIN_A_ROUTE 8'h17
`define GYC_IDX_PIN_ROUTE   8'h18
`define GYC_IDX_RATE_BASE   8'h40
`define GYC_IDX_STATUS      8'h46

// reset values
`define GYC_RST_RATE_CTRL   8'h00
`define GYC_RST_SRC_EN      8'h00
`define GYC_RST_PIN_CFG     8'h0F
`define GYC_RST_PIN_A_ROUTE 8'h00
`define GYC_RST_PIN_ROUTE   8'h00

// writable-bit masks; reserved bits read back as zero
`define GYC_MASK_RATE_CTRL  8'hC0
`define GYC_MASK_SRC_EN     8'hC4
`define GYC_MASK_PIN_CFG    8'h0F
`define GYC_MASK_PIN_A_ROUTE 8'h0A

// field positions
`define GYC_BIT_UNFILT      7
`define GYC_BIT_LOCK_DIS    6
`define GYC_BIT_NEW_EN      7
`define GYC_BIT_QUEUE_EN    6
`define GYC_BIT_BIAS_EN     2
`define GYC_BIT_B_DRIVE     3
`define GYC_BIT_B_POL       2
`define GYC_BIT_A_DRIVE     1
`define GYC_BIT_A_POL       0
`define GYC_BIT_A_FAST      3
`define GYC_BIT_A_MOTION    1
`define GYC_BIT_B_NEW       7
`define GYC_BIT_B_FBIAS     6
`define GYC_BIT_B_QUEUE     5
`define GYC_BIT_B_ABIAS     4
`define GYC_BIT_A_ABIAS     3
`define GYC_BIT_A_QUEUE     2
`define GYC_BIT_A_FBIAS     1
`define GYC_BIT_A_NEW       0

// restart command code and delay
`define GYC_RESTART_CODE    8'hB6
`define GYC_CLK_PERIOD_NS   8
`define GYC_RESTART_DELAY_NS 1000
`define GYC_RESTART_CYCLES  ((`GYC_RESTART_DELAY_NS + `GYC_CLK_PERIOD_NS - 1) / `GYC_CLK_PERIOD_NS)

// bus responses
`define GYC_RESP_OKAY       2'b00
`define GYC_RESP_SLVERR     2'b10

`endif

// [testbench/gyc_config_sva.sv]
// bus handshake, restart and pin drive checks for the rate configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "gyc_defines.vh"
module gyc_config_sva #(
  parameter integer RESTART_CYCLES = 4
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [9:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // core control and pins
  input wire logic        coreReset,
  input wire logic        irqPinAOut,
  input wire logic        irqPinAOe,
  input wire logic        irqPinBOut,
  input wire logic        irqPinBOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // slack covers the command write, the delay and the registered pulse
  localparam int RHI = RESTART_CYCLES + 3;
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_restart;
    s_wr ##0 (s_axi_awaddr[9:2] == `GYC_IDX_RESTART && s_axi_wstrb[0]
      && s_axi_wdata[7:0] == `GYC_RESTART_CODE);
  endsequence
  // the write lands one edge after both halves are held, so the answer is two edges out
  a_write_answer: assert property (s_wr |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_restart_done: assert property (s_restart |-> ##[1:RHI] coreReset)
    else $error("restart never completed");
  a_reset_pulse: assert property (coreReset |=> !coreReset)
    else $error("core reset longer than one cycle");
  a_pin_a_drive: assert property (!irqPinAOe |-> !irqPinAOut)
    else $error("pin a released high");
  a_pin_b_drive: assert property (!irqPinBOe |-> !irqPinBOut)
    else $error("pin b released high");
endmodule
bind gyc_config gyc_config_sva #(.RESTART_CYCLES(RESTART_CYCLES)) sva_u (.*);
`default_nettype wire

// [testbench/gyc_pin_host.sv]
// host-side view of the two interrupt pins, with board pull-ups
`timescale 1ns/1ps
`default_nettype none
module gyc_pin_host (
  // pin drivers
  input  wire logic irqPinAOut,
  input  wire logic irqPinAOe,
  input  wire logic irqPinBOut,
  input  wire logic irqPinBOe,
  // levels the host sees
  output wire logic pinA,
  output wire logic pinB
);
  // a released open-drain line floats up to the pull-up
  assign pinA = irqPinAOe ? irqPinAOut : 1'b1;
  assign pinB = irqPinBOe ? irqPinBOut : 1'b1;
endmodule
`default_nettype wire

// [testbench/gyc_config_test.sv]
// register, restart and interrupt pin tests for the rate configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "gyc_defines.vh"
module gyc_config_test;
  logic        ref_clk = 0, rst_n = 0;
  logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic [47:0] filteredRate = 0, unfilteredRate = 0;
  logic        sampleValid = 0, newSampleEvt = 0, queueEvt = 0;
  logic        fastBiasEvt = 0, autoBiasEvt = 0, fastRateEvt = 0, motionEvt = 0;
  wire         biasCorrectEn, coreReset, irqPinAOut, irqPinAOe, irqPinBOut, irqPinBOe;
  wire         pinA, pinB;
  integer      n_errors = 0, checked = 0;
  logic [7:0]  k;
  logic [7:0]  dflt [6] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
  logic [7:0]  wmsk [6] = '{8'hC0, 8'h00, 8'hC4, 8'h0F, 8'h0A, 8'hFF};

  gyc_config #(.RESTART_CYCLES(4)) dut_u (.*);
  gyc_pin_host host_u (.*);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // the idle edge at entry keeps two transfers from driving one step twice
  task wr(input [7:0] i, input [7:0] d, input [1:0] r);
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
        @(posedge ref_clk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, r);
    end
  endtask
  task rd(input [7:0] i, input [7:0] e);
    begin
      @(posedge ref_clk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
        @(posedge ref_clk);
        if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, {24'h0, e});
    end
  endtask
  task smp(input [47:0] f);
    begin
      @(posedge ref_clk);
      filteredRate <= f;
      unfilteredRate <= f ^ 48'h0000_0000_6666;
      sampleValid <= 1;
      @(posedge ref_clk);
      sampleValid <= 0;
    end
  endtask
  task pins(input [1:0] e);
    begin
      repeat (3) @(posedge ref_clk);
      chk({30'h0, pinA, pinB}, {30'h0, e});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    for (k = 0; k < 6; k++) rd(8'h13 + k, dflt[k]);
    // the host keeps reserved bits at zero, so it writes only the writable bits
    for (k = 0; k < 6; k++) wr(8'h13 + k, wmsk[k], `GYC_RESP_OKAY);
    for (k = 0; k < 6; k++) rd(8'h13 + k, wmsk[k]);
    wr(8'h30, 8'h01, `GYC_RESP_SLVERR);
    // the source choice is applied as a sample is taken, so select first
    wr(8'h13, 8'h00, `GYC_RESP_OKAY);
    smp(48'h0000_1122_A1B2);
    rd(8'h40, 8'hB2);
    wr(8'h13, 8'h80, `GYC_RESP_OKAY);
    smp(48'h0000_1122_A1B2);
    rd(8'h40, 8'hD4);
    smp(48'h0000_7788_5566);
    rd(8'h41, 8'hC7);
    rd(8'h41, 8'h33);
    wr(8'h13, 8'h40, `GYC_RESP_OKAY);
    rd(8'h42, 8'h88);
    smp(48'h0000_3344_5566);
    rd(8'h43, 8'h33);
    wr(8'h15, 8'h00, `GYC_RESP_OKAY);
    wr(8'h18, 8'h00, `GYC_RESP_OKAY);
    wr(8'h16, 8'h00, `GYC_RESP_OKAY);
    wr(8'h17, 8'h08, `GYC_RESP_OKAY);
    pins(2'b11);
    fastRateEvt <= 1;
    pins(2'b01);
    fastRateEvt <= 0;
    motionEvt <= 1;
    pins(2'b11);
    wr(8'h17, 8'h0A, `GYC_RESP_OKAY);
    pins(2'b01);
    motionEvt <= 0;
    wr(8'h18, 8'hA0, `GYC_RESP_OKAY);
    newSampleEvt <= 1;
    queueEvt <= 1;
    pins(2'b11);
    wr(8'h15, 8'h80, `GYC_RESP_OKAY);
    pins(2'b10);
    wr(8'h15, 8'h40, `GYC_RESP_OKAY);
    pins(2'b10);
    wr(8'h16, 8'h04, `GYC_RESP_OKAY);
    pins(2'b11);
    queueEvt <= 0;
    pins(2'b10);
    wr(8'h16, 8'h0F, `GYC_RESP_OKAY);
    pins(2'b00);
    queueEvt <= 1;
    pins(2'b01);
    chk({irqPinAOe, irqPinBOe}, 2'b10);
    wr(8'h18, 8'h01, `GYC_RESP_OKAY);
    wr(8'h15, 8'h80, `GYC_RESP_OKAY);
    pins(2'b10);
    wr(8'h15, 8'h04, `GYC_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(biasCorrectEn, 1);
    wr(8'h14, 8'h55, `GYC_RESP_OKAY);
    repeat (10) @(posedge ref_clk);
    rd(8'h15, 8'h04);
    wr(8'h14, 8'hB6, `GYC_RESP_OKAY);
    repeat (12) @(posedge ref_clk);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h0F);
    chk(biasCorrectEn, 0);
    wr(8'h15, 8'h04, `GYC_RESP_OKAY);
    rd(8'h15, 8'h04);
    final_report;
  end
  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    final_report;
  end
endmodule
`default_nettype wire
